// ---- logic/csb_regs.vh ----
// Constants for the colour sensor register bank: offsets, fields, resets.
// Assumes it is included by the bank module and the bench, by its bare name.
`ifndef CSB_REGS_VH
`define CSB_REGS_VH

// Seven-bit target address and identification value; both values arbitrary.
`define CSB_DEV_ADDR      7'h2A
`define CSB_ID_VALUE      8'h5A

// Register offsets.
`define CSB_OFF_ID        8'h01
`define CSB_OFF_CTRL      8'h02
`define CSB_OFF_BRIGHT    8'h03
`define CSB_OFF_RED       8'h04
`define CSB_OFF_GREEN     8'h05
`define CSB_OFF_BLUE      8'h06
`define CSB_OFF_CYAN      8'h07
`define CSB_OFF_MAGENTA   8'h08
`define CSB_OFF_YELLOW    8'h09
`define CSB_OFF_BLACK     8'h0A
`define CSB_OFF_GRAY      8'h0B
`define CSB_OFF_CLASS     8'h0C

// Control register fields.
`define CSB_CTRL_RESTORE  4
`define CSB_CTRL_PWR      3
`define CSB_CTRL_GAMMA    2
`define CSB_CTRL_MODE_HI  1
`define CSB_CTRL_MODE_LO  0
`define CSB_CTRL_RW       3:0

// Reset values.
`define CSB_CTRL_RST      5'h04
`define CSB_BYTE_RST      8'h00
`define CSB_CLASS_RST     4'h0

// Fill-light modes.
`define CSB_MODE_OFF      2'h0
`define CSB_MODE_RSVD     2'h1
`define CSB_MODE_MANUAL   2'h2
`define CSB_MODE_AUTO     2'h3

// Brightness PWM period end: a count of 255 leaves the light on always.
`define CSB_PWM_LAST      8'hFE
`define CSB_BIT_LAST      4'h7
`define CSB_BIT_FULL      4'h8

// Any byte at or above this value has its first-sent bit set.
`define CSB_MSB_SET       8'h80

`endif

// ---- logic/csb_regbank.v ----
// Register bank of the colour sensor, reached by an external serial-bus master.
// Assumes SCL and SDA arrive asynchronously; the wire is resolved outside.
// Result inputs come from the front end on core_clk.
//
// Notes on behaviour
// - Seven-bit addressed target; writes set, reads fetch.
// - Identification byte at 01h, always readable.
// - Control bit 4 written one restores defaults.
// - Control bit 3 power enable; register resets 04h.
// - Control bit 2 gamma enable, default on.
// - Control bits 1:0 fill-light mode, default 00.
// - Mode 00 keeps the light off.
// - Light runs automatic or host brightness.
// - Brightness register at 03h, resets zero.
// - Eight read-only colour results 04h to 0Bh.
// - Four-bit colour class at 0Ch, resets zero.
// - Mode 10 uses register, 11 automatic level.
// - Brightness scales linearly, 0 dim, 255 bright.
// - Class codes 0 to 13; 14, 15 reserved.
`timescale 1ns/1ps
`default_nettype none
`include "csb_regs.vh"

module csb_regbank (
  // Clock and reset
  input  wire       core_clk,
  input  wire       nrst,
  // Serial bus pins
  input  wire       scl_in,
  input  wire       sda_in,
  output wire       sda_out,
  output wire       sda_oe,
  // Results from the front end
  input  wire       result_load,
  input  wire [7:0] red_in,
  input  wire [7:0] green_in,
  input  wire [7:0] blue_in,
  input  wire [7:0] cyan_in,
  input  wire [7:0] magenta_in,
  input  wire [7:0] yellow_in,
  input  wire [7:0] black_in,
  input  wire [7:0] gray_in,
  input  wire [3:0] class_in,
  input  wire [7:0] auto_level_in,
  // Controls to the sensor
  output wire       power_on_bit,
  output wire       gamma_enable,
  output wire [1:0] illumination_mode_field,
  output wire [7:0] illumination_brightness,
  output wire       restore_pulse,
  output wire       led_drive
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_AACK = 3'h2;
  localparam [2:0] ST_WDAT = 3'h3;
  localparam [2:0] ST_WACK = 3'h4;
  localparam [2:0] ST_RDAT = 3'h5;
  localparam [2:0] ST_RACK = 3'h6;

  reg       rst_m_ff;
  reg       rst_s_ff;
  wire      rst_n;
  reg       scl_m_ff, scl_s_ff, scl_d_ff;
  reg       sda_m_ff, sda_s_ff, sda_d_ff;
  reg [2:0] state_ff;
  reg [3:0] bitcnt_ff;
  reg [7:0] shreg_ff;
  reg [7:0] txreg_ff;
  reg [7:0] ptr_ff;
  reg       rw_ff;
  reg       first_ff;
  reg       nack_ff;
  reg       drive_low_ff;
  reg       wr_en_ff;
  reg [7:0] wr_addr_ff;
  reg [7:0] wr_data_ff;
  reg [4:0] ctrl_ff;
  reg [7:0] bright_ff;
  reg [7:0] red_ff, green_ff, blue_ff, cyan_ff;
  reg [7:0] magenta_ff, yellow_ff, black_ff, gray_ff;
  reg [3:0] class_ff;
  reg       restore_ff;
  reg [7:0] pwm_cnt_ff;
  reg       led_ff;
  reg [7:0] duty;

  wire scl_rise = scl_s_ff & ~scl_d_ff;
  wire scl_fall = ~scl_s_ff & scl_d_ff;
  wire start_ev = scl_s_ff & scl_d_ff & sda_d_ff & ~sda_s_ff;
  wire stop_ev  = scl_s_ff & scl_d_ff & ~sda_d_ff & sda_s_ff;

  // Reset release through two flops.
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_m_ff <= 1'b0;
      rst_s_ff <= 1'b0;
    end else begin
      rst_m_ff <= 1'b1;
      rst_s_ff <= rst_m_ff;
    end
  end
  assign rst_n = rst_s_ff;

  // Pin synchronisers; only the second stage and its delayed copy are read.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_m_ff <= 1'b1;
      scl_s_ff <= 1'b1;
      scl_d_ff <= 1'b1;
      sda_m_ff <= 1'b1;
      sda_s_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_m_ff <= scl_in;
      scl_s_ff <= scl_m_ff;
      scl_d_ff <= scl_s_ff;
      sda_m_ff <= sda_in;
      sda_s_ff <= sda_m_ff;
      sda_d_ff <= sda_s_ff;
    end
  end

  // Read data for an offset; unmapped offsets and reserved bits read zero.
  function [7:0] rd_mux;
    input [7:0] a;
    begin
      case (a)
        `CSB_OFF_ID:      rd_mux = `CSB_ID_VALUE;
        `CSB_OFF_CTRL:    rd_mux = {4'h0, ctrl_ff[`CSB_CTRL_RW]};
        `CSB_OFF_BRIGHT:  rd_mux = bright_ff;
        `CSB_OFF_RED:     rd_mux = red_ff;
        `CSB_OFF_GREEN:   rd_mux = green_ff;
        `CSB_OFF_BLUE:    rd_mux = blue_ff;
        `CSB_OFF_CYAN:    rd_mux = cyan_ff;
        `CSB_OFF_MAGENTA: rd_mux = magenta_ff;
        `CSB_OFF_YELLOW:  rd_mux = yellow_ff;
        `CSB_OFF_BLACK:   rd_mux = black_ff;
        `CSB_OFF_GRAY:    rd_mux = gray_ff;
        `CSB_OFF_CLASS:   rd_mux = {4'h0, class_ff};
        default:          rd_mux = 8'h00;
      endcase
    end
  endfunction

  // Serial target engine. Bits are sampled on SCL rise and driven after SCL fall.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff     <= ST_IDLE;
      bitcnt_ff    <= 4'h0;
      shreg_ff     <= 8'h00;
      txreg_ff     <= 8'h00;
      ptr_ff       <= 8'h00;
      rw_ff        <= 1'b0;
      first_ff     <= 1'b0;
      nack_ff      <= 1'b0;
      drive_low_ff <= 1'b0;
      wr_en_ff     <= 1'b0;
      wr_addr_ff   <= 8'h00;
      wr_data_ff   <= 8'h00;
    end else begin
      wr_en_ff <= 1'b0;
      if (start_ev) begin
        state_ff     <= ST_ADDR;
        bitcnt_ff    <= 4'h0;
        drive_low_ff <= 1'b0;
      end else if (stop_ev) begin
        state_ff     <= ST_IDLE;
        drive_low_ff <= 1'b0;
      end else if (scl_rise) begin
        if (state_ff == ST_ADDR || state_ff == ST_WDAT) begin
          shreg_ff  <= {shreg_ff[6:0], sda_s_ff};
          bitcnt_ff <= bitcnt_ff + 4'h1;
        end else if (state_ff == ST_RACK) begin
          nack_ff <= sda_s_ff;
        end
      end else if (scl_fall) begin
        case (state_ff)
          ST_ADDR: begin
            if (bitcnt_ff == `CSB_BIT_FULL) begin
              if (shreg_ff[7:1] == `CSB_DEV_ADDR) begin
                state_ff     <= ST_AACK;
                rw_ff        <= shreg_ff[0];
                drive_low_ff <= 1'b1;
              end else begin
                state_ff <= ST_IDLE;
              end
            end
          end
          ST_AACK: begin
            bitcnt_ff <= 4'h0;
            if (rw_ff) begin
              state_ff     <= ST_RDAT;
              txreg_ff     <= rd_mux(ptr_ff);
              drive_low_ff <= (rd_mux(ptr_ff) < `CSB_MSB_SET);
            end else begin
              state_ff     <= ST_WDAT;
              first_ff     <= 1'b1;
              drive_low_ff <= 1'b0;
            end
          end
          ST_WDAT: begin
            if (bitcnt_ff == `CSB_BIT_FULL) begin
              state_ff     <= ST_WACK;
              drive_low_ff <= 1'b1;
              first_ff     <= 1'b0;
              if (first_ff) begin
                ptr_ff <= shreg_ff;
              end else begin
                wr_en_ff   <= 1'b1;
                wr_addr_ff <= ptr_ff;
                wr_data_ff <= shreg_ff;
                ptr_ff     <= ptr_ff + 8'h01;
              end
            end
          end
          ST_WACK: begin
            state_ff     <= ST_WDAT;
            bitcnt_ff    <= 4'h0;
            drive_low_ff <= 1'b0;
          end
          ST_RDAT: begin
            if (bitcnt_ff == `CSB_BIT_LAST) begin
              state_ff     <= ST_RACK;
              drive_low_ff <= 1'b0;
            end else begin
              txreg_ff     <= {txreg_ff[6:0], 1'b0};
              drive_low_ff <= ~txreg_ff[6];
              bitcnt_ff    <= bitcnt_ff + 4'h1;
            end
          end
          ST_RACK: begin
            if (nack_ff) begin
              state_ff <= ST_IDLE;
            end else begin
              state_ff     <= ST_RDAT;
              bitcnt_ff    <= 4'h0;
              ptr_ff       <= ptr_ff + 8'h01;
              txreg_ff     <= rd_mux(ptr_ff + 8'h01);
              drive_low_ff <= (rd_mux(ptr_ff + 8'h01) < `CSB_MSB_SET);
            end
          end
          default: state_ff <= ST_IDLE;
        endcase
      end
    end
  end

  // Open-drain data pin: only ever pulled low.
  assign sda_out = 1'b0;
  assign sda_oe  = drive_low_ff;

  // Register file. A restore takes one cycle after the write that asks for it.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff    <= `CSB_CTRL_RST;
      bright_ff  <= `CSB_BYTE_RST;
      restore_ff <= 1'b0;
      red_ff     <= `CSB_BYTE_RST;
      green_ff   <= `CSB_BYTE_RST;
      blue_ff    <= `CSB_BYTE_RST;
      cyan_ff    <= `CSB_BYTE_RST;
      magenta_ff <= `CSB_BYTE_RST;
      yellow_ff  <= `CSB_BYTE_RST;
      black_ff   <= `CSB_BYTE_RST;
      gray_ff    <= `CSB_BYTE_RST;
      class_ff   <= `CSB_CLASS_RST;
    end else if (restore_ff) begin
      ctrl_ff    <= `CSB_CTRL_RST;
      bright_ff  <= `CSB_BYTE_RST;
      restore_ff <= 1'b0;
      red_ff     <= `CSB_BYTE_RST;
      green_ff   <= `CSB_BYTE_RST;
      blue_ff    <= `CSB_BYTE_RST;
      cyan_ff    <= `CSB_BYTE_RST;
      magenta_ff <= `CSB_BYTE_RST;
      yellow_ff  <= `CSB_BYTE_RST;
      black_ff   <= `CSB_BYTE_RST;
      gray_ff    <= `CSB_BYTE_RST;
      class_ff   <= `CSB_CLASS_RST;
    end else begin
      if (wr_en_ff && wr_addr_ff == `CSB_OFF_CTRL) begin
        ctrl_ff[`CSB_CTRL_RW] <= wr_data_ff[`CSB_CTRL_RW];
        restore_ff            <= wr_data_ff[`CSB_CTRL_RESTORE];
      end
      if (wr_en_ff && wr_addr_ff == `CSB_OFF_BRIGHT) begin
        bright_ff <= wr_data_ff;
      end
      // Results only refresh while the sensor is powered.
      if (result_load && ctrl_ff[`CSB_CTRL_PWR]) begin
        red_ff     <= red_in;
        green_ff   <= green_in;
        blue_ff    <= blue_in;
        cyan_ff    <= cyan_in;
        magenta_ff <= magenta_in;
        yellow_ff  <= yellow_in;
        black_ff   <= black_in;
        gray_ff    <= gray_in;
        class_ff   <= class_in;
      end
    end
  end

  // Fill-light duty selection.
  always @* begin
    case (ctrl_ff[`CSB_CTRL_MODE_HI:`CSB_CTRL_MODE_LO])
      `CSB_MODE_OFF:    duty = 8'h00;
      `CSB_MODE_MANUAL: duty = bright_ff;
      `CSB_MODE_AUTO:   duty = auto_level_in;
      default:          duty = 8'h00;
    endcase
  end

  // PWM over 255 steps, so duty 0 never lights and 255 always does.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwm_cnt_ff <= 8'h00;
      led_ff     <= 1'b0;
    end else begin
      if (pwm_cnt_ff == `CSB_PWM_LAST) begin
        pwm_cnt_ff <= 8'h00;
      end else begin
        pwm_cnt_ff <= pwm_cnt_ff + 8'h01;
      end
      led_ff <= ctrl_ff[`CSB_CTRL_PWR] && (pwm_cnt_ff < duty);
    end
  end

  assign power_on_bit            = ctrl_ff[`CSB_CTRL_PWR];
  assign gamma_enable            = ctrl_ff[`CSB_CTRL_GAMMA];
  assign illumination_mode_field = ctrl_ff[`CSB_CTRL_MODE_HI:`CSB_CTRL_MODE_LO];
  assign illumination_brightness = bright_ff;
  assign restore_pulse           = restore_ff;
  assign led_drive               = led_ff;

endmodule // csb_regbank

`default_nettype wire

// ---- tb/csb_regbank_properties.sv ----
// Checker for the colour sensor register bank outputs.
// Assumes the bank's port names; bound at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
module csb_regbank_properties (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       nrst,
  // Bus and controls
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic       power_on_bit,
  input wire logic       gamma_enable,
  input wire logic [1:0] illumination_mode_field,
  input wire logic [7:0] illumination_brightness,
  input wire logic       restore_pulse,
  input wire logic       led_drive
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  a_sda_open_drain: assert property (sda_out == 1'b0)
    else $error("sda_out driven high");
  a_reset_defaults: assert property (disable iff (1'b0) !nrst [*2] |->
    !sda_oe && gamma_enable && !power_on_bit && !led_drive) else $error("not reset");
  a_restore_clears: assert property (restore_pulse |=> !power_on_bit && gamma_enable
    && illumination_mode_field == 2'h0 && illumination_brightness == 8'h00)
    else $error("restore left state");
  a_restore_single: assert property (restore_pulse |=> !restore_pulse)
    else $error("restore pulse too long");
  a_led_mode_off: assert property (illumination_mode_field == 2'h0 |=> !led_drive)
    else $error("light on in mode 0");
  a_led_unpowered: assert property (!power_on_bit |=> !led_drive)
    else $error("light on unpowered");
  a_led_reserved_off: assert property (illumination_mode_field == 2'h1 |=> !led_drive)
    else $error("light on in mode 1");
  a_led_full_scale: assert property (power_on_bit && illumination_mode_field == 2'h2
    && illumination_brightness == 8'hFF |=> led_drive) else $error("full scale not on");
  a_led_zero_scale: assert property (illumination_mode_field == 2'h2
    && illumination_brightness == 8'h00 |=> !led_drive) else $error("zero scale lit");
endmodule // csb_regbank_properties
bind csb_regbank csb_regbank_properties u_csb_regbank_properties (
  .core_clk                (core_clk),
  .nrst                    (nrst),
  .sda_out                 (sda_out),
  .sda_oe                  (sda_oe),
  .power_on_bit            (power_on_bit),
  .gamma_enable            (gamma_enable),
  .illumination_mode_field (illumination_mode_field),
  .illumination_brightness (illumination_brightness),
  .restore_pulse           (restore_pulse),
  .led_drive               (led_drive)
);
`default_nettype wire

// ---- tb/csb_i2c_master.sv ----
// Serial-bus master model driving the bank's bus pins.
// Assumes the bench resolves SDA with a pull-up; times are core_clk cycles.
`timescale 1ns/1ps
`default_nettype none
module csb_i2c_master (
  input  wire logic clk,
  input  wire logic sda,
  output var  logic scl,
  output var  logic pull
);
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end
  task automatic q(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Data moves one cycle after SCL falls, so it never looks like START or STOP.
  task automatic bitx(input logic b, output logic r);
    pull <= !b;
    q(3);
    scl <= 1'b1;
    q(4);
    r = sda;
    scl <= 1'b0;
    q(1);
  endtask
  task automatic start();
    pull <= 1'b0;
    q(3);
    scl <= 1'b1;
    q(4);
    pull <= 1'b1;
    q(4);
    scl <= 1'b0;
    q(1);
  endtask
  task automatic stop();
    pull <= 1'b1;
    q(3);
    scl <= 1'b1;
    q(4);
    pull <= 1'b0;
    q(4);
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, r);
    ack = !r;
  endtask
  task automatic recv(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, r);
      d[i] = r;
    end
    bitx(last, r);
  endtask
endmodule // csb_i2c_master
`default_nettype wire

// ---- tb/csb_regbank_tb.sv ----
// Self-checking bench for the colour sensor register bank.
// Assumes csb_regs.vh is on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "csb_regs.vh"
module csb_regbank_tb;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic result_load = 1'b0;
  logic [7:0] red_in = 8'h81, green_in = 8'h42, blue_in = 8'h24, cyan_in = 8'h18;
  logic [7:0] magenta_in = 8'hC3, yellow_in = 8'h3C, black_in = 8'h7E, gray_in = 8'hE7;
  logic [3:0] class_in = 4'hD;
  logic [7:0] auto_level_in = 8'h40;
  logic pull;
  wire scl_in, sda_in, sda_out, sda_oe, power_on_bit, gamma_enable, restore_pulse, led_drive;
  wire [1:0] illumination_mode_field;
  wire [7:0] illumination_brightness;
  int bad_count = 0;
  int checks_done = 0;
  assign sda_in = !(pull | (sda_oe & !sda_out));
  always #20 core_clk = ~core_clk;
  csb_i2c_master u_csb_i2c_master (.clk(core_clk), .sda(sda_in), .scl(scl_in), .pull(pull));
  csb_regbank u_csb_regbank (
    .core_clk                (core_clk),
    .nrst                    (nrst),
    .scl_in                  (scl_in),
    .sda_in                  (sda_in),
    .sda_out                 (sda_out),
    .sda_oe                  (sda_oe),
    .result_load             (result_load),
    .red_in                  (red_in),
    .green_in                (green_in),
    .blue_in                 (blue_in),
    .cyan_in                 (cyan_in),
    .magenta_in              (magenta_in),
    .yellow_in               (yellow_in),
    .black_in                (black_in),
    .gray_in                 (gray_in),
    .class_in                (class_in),
    .auto_level_in           (auto_level_in),
    .power_on_bit            (power_on_bit),
    .gamma_enable            (gamma_enable),
    .illumination_mode_field (illumination_mode_field),
    .illumination_brightness (illumination_brightness),
    .restore_pulse           (restore_pulse),
    .led_drive               (led_drive)
  );
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic a;
    u_csb_i2c_master.start();
    u_csb_i2c_master.send({`CSB_DEV_ADDR, 1'b0}, a);
    u_csb_i2c_master.send(p, a);
    u_csb_i2c_master.send(d, a);
    u_csb_i2c_master.stop();
    chk({7'h00, a}, 8'h01);
  endtask
  // Expected bytes arrive right-aligned in e, first byte read in the highest of n bytes.
  task automatic rd(input logic [7:0] p, input int n, input logic [95:0] e);
    logic a;
    logic [7:0] d;
    u_csb_i2c_master.start();
    u_csb_i2c_master.send({`CSB_DEV_ADDR, 1'b0}, a);
    u_csb_i2c_master.send(p, a);
    u_csb_i2c_master.start();
    u_csb_i2c_master.send({`CSB_DEV_ADDR, 1'b1}, a);
    for (int i = 0; i < n; i++) begin
      u_csb_i2c_master.recv(i == n - 1, d);
      chk(d, e[8 * (n - 1 - i) +: 8]);
    end
    u_csb_i2c_master.stop();
  endtask
  task automatic led_count(input logic [7:0] e);
    logic [7:0] n;
    n = 8'h00;
    // Sampled mid-cycle so the value seen is the settled one.
    repeat (255) @(negedge core_clk) n = n + {7'h00, led_drive};
    chk(n, e);
    @(posedge core_clk);
  endtask
  task automatic t_defaults();
    rd(8'h01, 12, {`CSB_ID_VALUE, 8'h04, 80'h0});
  endtask
  task automatic t_nack();
    logic a;
    u_csb_i2c_master.start();
    u_csb_i2c_master.send({`CSB_DEV_ADDR + 7'h01, 1'b0}, a);
    u_csb_i2c_master.stop();
    chk({7'h00, a}, 8'h00);
  endtask
  task automatic t_ctrl();
    wr(8'h02, 8'hEB);
    chk({4'h0, power_on_bit, gamma_enable, illumination_mode_field}, 8'h0B);
    wr(8'h01, 8'h00);
    wr(8'h04, 8'hFF);
    rd(8'h01, 4, {`CSB_ID_VALUE, 8'h0B, 16'h0000});
  endtask
  task automatic t_results();
    @(posedge core_clk) result_load <= 1'b1;
    @(posedge core_clk) result_load <= 1'b0;
    rd(8'h04, 9, {red_in, green_in, blue_in, cyan_in, magenta_in, yellow_in,
      black_in, gray_in, 4'h0, class_in});
  endtask
  task automatic t_light();
    led_count(auto_level_in);
    wr(8'h02, 8'h0A);
    led_count(8'h00);
    wr(8'h03, 8'h80);
    led_count(8'h80);
    wr(8'h03, 8'hFF);
    led_count(8'hFF);
    rd(8'h02, 2, {8'h0A, 8'hFF});
    wr(8'h02, 8'h09);
    led_count(8'h00);
    wr(8'h02, 8'h08);
    led_count(8'h00);
  endtask
  task automatic t_restore();
    wr(8'h02, 8'h1B);
    chk(illumination_brightness, 8'h00);
    t_defaults();
  endtask
  task automatic end_sim();
    $display("Checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (6) @(posedge core_clk);
    t_defaults();
    t_nack();
    t_ctrl();
    t_results();
    t_light();
    t_restore();
    end_sim();
  end
endmodule // csb_regbank_tb
`default_nettype wire
